// file: logic/syp_consts.svh
// Constants of the synchronous serial port
`ifndef SYP_CONSTS_SVH
`define SYP_CONSTS_SVH
// System clock period
`define SYP_CLK_NS 10
// SPI serial clock half period
`define SYP_HALF_NS 250
`define SYP_HALF_CYC ((`SYP_HALF_NS + `SYP_CLK_NS - 1) / `SYP_CLK_NS)
// Half-period step numbers of one SPI byte
`define SYP_STEP_FIRST 5'h00
`define SYP_STEP_LAST 5'h0f
`define SYP_STEP_FINAL 5'h10
// Link bit counter values
`define SYP_BIT_LAST 4'h7
`define SYP_BIT_ACK 4'h8
// Reset values
`define SYP_BYTE_RST 8'h00
`define SYP_CNT_RST 4'h0
`define SYP_TIMER_RST 8'h00
`endif

// file: logic/syp_pkg.sv
// Types of the synchronous serial port
package syp_pkg;
    // I2C slave states
    typedef enum logic [3:0] {
        SYP_I2_IDLE = 4'h1,
        SYP_I2_ADDR = 4'h2,
        SYP_I2_DATA = 4'h4,
        SYP_I2_SKIP = 4'h8
    } syp_i2c_state_type;
    // SPI master states
    typedef enum logic [1:0] {
        SYP_SPI_IDLE = 2'h1,
        SYP_SPI_RUN  = 2'h2
    } syp_spi_state_type;
    // Software configuration
    typedef struct packed {
        logic       enable;
        logic       spi_mode;
        logic       clock_edge_select;
        logic       clock_polarity_select;
        logic       input_sample_phase;
        logic [6:0] own_addr;
    } syp_cfg_type;
    // Status seen by software
    typedef struct packed {
        logic buffer_full_flag;
        logic receive_overflow_flag;
        logic busy;
        logic addressed;
    } syp_status_type;
endpackage

// file: logic/syp_port.sv
// Synchronous serial port: I2C address-matching slave and SPI master
//
// Operation
// - Matching address byte while buffer full sets overflow and is not acknowledged.
// - Overflow set, buffer empty, matching address: no load, no acknowledge.
// - SPI master, edge select clear, late sampling: last bit sampled correctly.
// - SPI master, edge select set: slave-select fall never reloads shifter.
// - Enabling SPI master must not glitch the serial clock pin.
`timescale 1ns/10ps
`include "syp_consts.svh"
`default_nettype none
module syp_port (
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_n_i,
    // Software side
    input  wire syp_pkg::syp_cfg_type cfg_i,
    input  wire logic                 buf_wr_i,
    input  wire logic [7:0]           buf_wdata_i,
    input  wire logic                 buf_rd_i,
    input  wire logic                 ovf_clr_i,
    output var  logic [7:0]           buf_o,
    output var  syp_pkg::syp_status_type status_o,
    // SPI pins
    output var  logic                 sck_o,
    output var  logic                 sck_oe_o,
    output var  logic                 sdo_o,
    input  wire logic                 sdi_i,
    // I2C pins, serial clock is the link clock
    input  wire logic                 scl_clk_i,
    input  wire logic                 sda_i,
    output var  logic                 sda_o,
    output var  logic                 sda_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic                          rst_q1, rst_n;
    logic                          scl_q1, scl_q2, scl_q3;
    logic                          sda_q1, sda_q2, sda_q3;
    logic                          sdi_q1, sdi_q2;
    logic                          tg_q1, tg_q2, tg_q3;
    logic                          lk_clr, next_lk_clr;
    logic [7:0]                    lk_sh, next_lk_sh;
    logic [3:0]                    lk_cnt, next_lk_cnt;
    logic [7:0]                    lk_byte, next_lk_byte;
    logic                          lk_tgl, next_lk_tgl;
    syp_pkg::syp_i2c_state_type    i2s, next_i2s;
    syp_pkg::syp_spi_state_type    sps, next_sps;
    logic                          ack_pend, next_ack_pend;
    logic                          sda_oe, next_sda_oe;
    logic                          addressed, next_addressed;
    logic [7:0]                    timer, next_timer;
    logic [4:0]                    step, next_step;
    logic [7:0]                    tx_sh, next_tx_sh;
    logic [7:0]                    rx_sh, next_rx_sh;
    logic                          sck, next_sck;
    logic                          sck_oe, next_sck_oe;
    logic                          sdo, next_sdo;
    logic [7:0]                    buffer, next_buffer;
    logic                          bf, next_bf;
    logic                          ovf, next_ovf;
    logic                          start_ev, stop_ev, scl_fall, byte_ev;
    logic                          load, set_ovf, accept, ovf_hit, fin;
    logic [7:0]                    load_data;

    // Verdict on a received I2C byte: {accept, set overflow}
    function automatic logic [1:0] rx_verdict(input logic full, input logic over);
        if (full)
            rx_verdict = 2'h1;
        else if (over)
            rx_verdict = 2'h0;
        else
            rx_verdict = 2'h2;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Two flops per pin, a third copy only for edge detection
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            {scl_q1, scl_q2, scl_q3} <= 3'h7;
            {sda_q1, sda_q2, sda_q3} <= 3'h7;
            {sdi_q1, sdi_q2}         <= 2'h0;
            {tg_q1, tg_q2, tg_q3}    <= 3'h0;
        end else begin
            {scl_q1, scl_q2, scl_q3} <= {scl_clk_i, scl_q1, scl_q2};
            {sda_q1, sda_q2, sda_q3} <= {sda_i, sda_q1, sda_q2};
            {sdi_q1, sdi_q2}         <= {sdi_i, sdi_q1};
            {tg_q1, tg_q2, tg_q3}    <= {lk_tgl, tg_q1, tg_q2};
        end
    end

    // Bus events seen in the system domain
    assign start_ev = scl_q2 & scl_q3 & sda_q3 & ~sda_q2;
    assign stop_ev  = scl_q2 & scl_q3 & ~sda_q3 & sda_q2;
    assign scl_fall = scl_q3 & ~scl_q2;
    assign byte_ev  = tg_q2 ^ tg_q3;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: bit shifter on the serial clock
    always_comb begin
        next_lk_sh   = {lk_sh[6:0], sda_i};
        next_lk_cnt  = (lk_cnt == `SYP_BIT_ACK) ? `SYP_CNT_RST : 4'(lk_cnt + 4'h1);
        next_lk_byte = lk_byte;
        next_lk_tgl  = lk_tgl;
        // Eighth bit completes a byte; toggle tells the system side
        if (lk_cnt == `SYP_BIT_LAST) begin
            next_lk_byte = {lk_sh[6:0], sda_i};
            next_lk_tgl  = ~lk_tgl;
        end
    end

    // Framing state, cleared from start condition until clock low
    always_ff @(posedge scl_clk_i or posedge lk_clr) begin
        if (lk_clr) begin
            lk_sh  <= `SYP_BYTE_RST;
            lk_cnt <= `SYP_CNT_RST;
        end else begin
            lk_sh  <= next_lk_sh;
            lk_cnt <= next_lk_cnt;
        end
    end

    // Byte word and its toggle survive frame clearing
    always_ff @(posedge scl_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lk_byte <= `SYP_BYTE_RST;
            lk_tgl  <= 1'b0;
        end else begin
            lk_byte <= next_lk_byte;
            lk_tgl  <= next_lk_tgl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: I2C slave, SPI master, buffer and flags
    always_comb begin
        next_lk_clr    = lk_clr;
        next_i2s       = i2s;
        next_ack_pend  = ack_pend;
        next_sda_oe    = sda_oe;
        next_addressed = addressed;
        next_sps       = sps;
        next_timer     = timer;
        next_step      = step;
        next_tx_sh     = tx_sh;
        next_rx_sh     = rx_sh;
        next_sck       = sck;
        next_sck_oe    = sck_oe;
        next_sdo       = sdo;
        load           = 1'b0;
        set_ovf        = 1'b0;
        load_data      = lk_byte;
        {accept, ovf_hit} = rx_verdict(bf, ovf);
        fin            = 1'b0;

        // I2C slave
        if (!cfg_i.enable || cfg_i.spi_mode) begin
            next_i2s       = syp_pkg::SYP_I2_IDLE;
            next_lk_clr    = 1'b1;
            next_ack_pend  = 1'b0;
            next_sda_oe    = 1'b0;
            next_addressed = 1'b0;
        end else begin
            if (!scl_q2 && i2s != syp_pkg::SYP_I2_IDLE)
                next_lk_clr = 1'b0;
            // Acknowledge held low for one serial clock low-high period
            if (scl_fall) begin
                if (sda_oe) begin
                    next_sda_oe = 1'b0;
                end else if (ack_pend) begin
                    next_sda_oe   = 1'b1;
                    next_ack_pend = 1'b0;
                end
            end
            if (start_ev) begin
                next_i2s       = syp_pkg::SYP_I2_ADDR;
                next_lk_clr    = 1'b1;
                next_addressed = 1'b0;
                next_ack_pend  = 1'b0;
            end else if (stop_ev) begin
                next_i2s       = syp_pkg::SYP_I2_IDLE;
                next_lk_clr    = 1'b1;
                next_addressed = 1'b0;
            end else if (byte_ev) begin
                case (i2s)
                    syp_pkg::SYP_I2_ADDR: begin
                        next_i2s = syp_pkg::SYP_I2_SKIP;
                        if (lk_byte[7:1] == cfg_i.own_addr) begin
                            set_ovf = ovf_hit;
                            if (accept) begin
                                load           = 1'b1;
                                next_ack_pend  = 1'b1;
                                next_addressed = 1'b1;
                                next_i2s       = lk_byte[0] ? syp_pkg::SYP_I2_SKIP : syp_pkg::SYP_I2_DATA;
                            end
                        end
                    end
                    syp_pkg::SYP_I2_DATA: begin
                        set_ovf = ovf_hit;
                        if (accept) begin
                            load          = 1'b1;
                            next_ack_pend = 1'b1;
                        end else begin
                            next_i2s = syp_pkg::SYP_I2_SKIP;
                        end
                    end
                    default: begin
                        next_i2s = i2s;
                    end
                endcase
            end
        end

        // SPI master
        if (!cfg_i.enable || !cfg_i.spi_mode) begin
            next_sps    = syp_pkg::SYP_SPI_IDLE;
            next_sck    = cfg_i.clock_polarity_select;
            next_sck_oe = 1'b0;
        end else begin
            // Clock already rests at idle level when the pin is enabled
            next_sck_oe = 1'b1;
            case (sps)
                syp_pkg::SYP_SPI_IDLE: begin
                    next_sck = cfg_i.clock_polarity_select;
                    // Only a software write loads the shifter
                    if (buf_wr_i) begin
                        next_sps   = syp_pkg::SYP_SPI_RUN;
                        next_tx_sh = buf_wdata_i;
                        next_timer = 8'(`SYP_HALF_CYC - 1);
                        next_step  = `SYP_STEP_FIRST;
                        if (cfg_i.clock_edge_select)
                            next_sdo = buf_wdata_i[7];
                    end
                end
                syp_pkg::SYP_SPI_RUN: begin
                    if (timer != `SYP_TIMER_RST) begin
                        next_timer = 8'(timer - 8'h01);
                    end else begin
                        next_timer = 8'(`SYP_HALF_CYC - 1);
                        next_step  = 5'(step + 5'h01);
                        if (!step[0]) begin
                            // Leading edge, or the closing sample slot
                            if (step != `SYP_STEP_FINAL)
                                next_sck = ~cfg_i.clock_polarity_select;
                            if (cfg_i.clock_edge_select) begin
                                if (!cfg_i.input_sample_phase)
                                    next_rx_sh = {rx_sh[6:0], sdi_q2};
                            end else begin
                                if (step != `SYP_STEP_FIRST && cfg_i.input_sample_phase)
                                    next_rx_sh = {rx_sh[6:0], sdi_q2};
                                if (step != `SYP_STEP_FINAL) begin
                                    next_sdo   = tx_sh[7];
                                    next_tx_sh = {tx_sh[6:0], 1'b0};
                                end
                            end
                        end else begin
                            // Trailing edge
                            next_sck = cfg_i.clock_polarity_select;
                            if (cfg_i.clock_edge_select) begin
                                if (cfg_i.input_sample_phase)
                                    next_rx_sh = {rx_sh[6:0], sdi_q2};
                                next_sdo   = tx_sh[6];
                                next_tx_sh = {tx_sh[6:0], 1'b0};
                            end else if (!cfg_i.input_sample_phase) begin
                                next_rx_sh = {rx_sh[6:0], sdi_q2};
                            end
                        end
                        // Late sampling with edge select clear needs one more half
                        if (step == `SYP_STEP_FINAL)
                            fin = 1'b1;
                        else if (step == `SYP_STEP_LAST)
                            fin = cfg_i.clock_edge_select | ~cfg_i.input_sample_phase;
                        if (fin) begin
                            next_sps = syp_pkg::SYP_SPI_IDLE;
                            set_ovf  = bf;
                            load     = ~bf;
                            load_data = next_rx_sh;
                        end
                    end
                end
                default: begin
                    next_sps = syp_pkg::SYP_SPI_IDLE;
                end
            endcase
        end
    end

    // Buffer and flags; a set wins over a clear in the same cycle
    always_comb begin
        next_buffer = load ? load_data : buffer;
        next_bf     = load | (bf & ~buf_rd_i);
        next_ovf    = set_ovf | (ovf & ~ovf_clr_i);
    end

    // System domain registers
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lk_clr    <= 1'b1;
            i2s       <= syp_pkg::SYP_I2_IDLE;
            ack_pend  <= 1'b0;
            sda_oe    <= 1'b0;
            addressed <= 1'b0;
            sps       <= syp_pkg::SYP_SPI_IDLE;
            timer     <= `SYP_TIMER_RST;
            step      <= `SYP_STEP_FIRST;
            tx_sh     <= `SYP_BYTE_RST;
            rx_sh     <= `SYP_BYTE_RST;
            sck       <= 1'b0;
            sck_oe    <= 1'b0;
            sdo       <= 1'b0;
            buffer    <= `SYP_BYTE_RST;
            bf        <= 1'b0;
            ovf       <= 1'b0;
        end else begin
            lk_clr    <= next_lk_clr;
            i2s       <= next_i2s;
            ack_pend  <= next_ack_pend;
            sda_oe    <= next_sda_oe;
            addressed <= next_addressed;
            sps       <= next_sps;
            timer     <= next_timer;
            step      <= next_step;
            tx_sh     <= next_tx_sh;
            rx_sh     <= next_rx_sh;
            sck       <= next_sck;
            sck_oe    <= next_sck_oe;
            sdo       <= next_sdo;
            buffer    <= next_buffer;
            bf        <= next_bf;
            ovf       <= next_ovf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs from flops, except busy decoded from the SPI state and sda_o tied low
    assign buf_o    = buffer;
    assign status_o = {bf, ovf, (sps == syp_pkg::SYP_SPI_RUN), addressed};
    assign sck_o    = sck;
    assign sck_oe_o = sck_oe;
    assign sdo_o    = sdo;
    assign sda_o    = 1'b0;  // Open drain: only ever pulls low
    assign sda_oe_o = sda_oe;

endmodule
`default_nettype wire

// file: tb/syp_peer.sv
// Far-side peer: SPI slave and I2C bus master
`timescale 1ns/10ps
`default_nettype none
module syp_peer (
    // SPI side
    input  wire logic sck_i,
    input  wire logic sdo_i,
    input  wire logic cke_i,
    input  wire logic pol_i,
    output var  logic sdi_o,
    // I2C side
    input  wire logic sda_oe_i,
    output var  logic scl_o,
    output wire logic sda_o
);
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    int         bit_n;
    logic       sda_drv;
    // Open-drain data line, pulled up when nobody pulls low
    assign sda_o = sda_drv & ~sda_oe_i;
    initial begin
        sdi_o = 1'b0;
        scl_o = 1'b1;
        sda_drv = 1'b1;
    end
    // Arm a byte; with late first edge the line shows the wrong level
    task automatic spi_load(input logic [7:0] d);
        tx_byte = d;
        rx_byte = 8'h00;
        bit_n = 0;
        sdi_o = cke_i ? d[7] : ~d[7];
    endtask
    // Shift out on the same edge on which the master shifts out its data
    always @(sck_i) begin
        if ((sck_i != pol_i) != cke_i) begin
            if (cke_i) bit_n++;
            sdi_o = (bit_n < 8) ? tx_byte[7 - bit_n] : ~sdi_o;
            if (!cke_i) bit_n++;
        end else begin
            rx_byte = {rx_byte[6:0], sdo_i};
        end
    end
    // Link clock only runs inside frames, 160 ns period
    task automatic i2c_start();
        #80 sda_drv = 1'b0;
        #80 scl_o = 1'b0;
    endtask
    task automatic i2c_byte(input logic [7:0] d, output logic acked);
        for (int i = 0; i < 9; i++) begin
            #20 sda_drv = (i < 8) ? d[7 - i] : 1'b1;
            #60 scl_o = 1'b1;
            if (i == 8) acked = ~sda_o;
            #80 scl_o = 1'b0;
        end
    endtask
    task automatic i2c_stop();
        #20 sda_drv = 1'b0;
        #60 scl_o = 1'b1;
        #80 sda_drv = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

// file: tb/syp_port_checker.sv
// Concurrent checks on the serial port's pins and status
`timescale 1ns/10ps
`default_nettype none
module syp_port_checker (
    input wire logic                    sys_clk_i,
    input wire logic                    reset_n_i,
    input wire syp_pkg::syp_cfg_type    cfg_i,
    input wire logic                    buf_wr_i,
    input wire logic [7:0]              buf_wdata_i,
    input wire logic [7:0]              buf_o,
    input wire syp_pkg::syp_status_type status_o,
    input wire logic                    sck_o,
    input wire logic                    sck_oe_o,
    input wire logic                    sdo_o,
    input wire logic                    sda_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Write that the port has to take
    sequence s_wr_taken;
        buf_wr_i && cfg_i.enable && cfg_i.spi_mode && !status_o.busy;
    endsequence
    // SPI master enabled, idle, configuration settled
    sequence s_spi_idle;
        cfg_i.enable && cfg_i.spi_mode && !status_o.busy && $stable(cfg_i) && $past(reset_n_i, 4);
    endsequence
    // Acknowledge on the data line
    sequence s_ack;
        $rose(sda_oe_o);
    endsequence
    AST_SCK_IDLE: assert property (s_spi_idle |-> sck_o == cfg_i.clock_polarity_select)
        else $error("serial clock left its idle level");
    AST_SCK_OE: assert property (cfg_i.enable && cfg_i.spi_mode && $past(cfg_i.enable && cfg_i.spi_mode)
        && $past(reset_n_i, 4) |-> sck_oe_o)
        else $error("serial clock not driven while enabled");
    AST_WR_START: assert property (s_wr_taken |=> status_o.busy
        && (!cfg_i.clock_edge_select || sdo_o == $past(buf_wdata_i[7])))
        else $error("byte not launched from the written value");
    AST_BUSY_CAUSE: assert property ($rose(status_o.busy) |-> $past(buf_wr_i))
        else $error("shifter started without a write");
    AST_OVF_CAUSE: assert property ($rose(status_o.receive_overflow_flag)
        |-> $past(status_o.buffer_full_flag))
        else $error("overflow set with buffer empty");
    AST_ACK_FRESH: assert property (s_ack |-> !$past(status_o.buffer_full_flag, 14)
        && status_o.buffer_full_flag)
        else $error("acknowledge while buffer was full");
    AST_ACK_NO_OVF: assert property (s_ack |-> !status_o.receive_overflow_flag
        && !$past(status_o.receive_overflow_flag, 14))
        else $error("acknowledge while overflow set");
    AST_BUF_HOLD: assert property (buf_o != $past(buf_o) |-> $rose(status_o.buffer_full_flag))
        else $error("buffer changed without a load");
endmodule
`default_nettype wire

// file: tb/test_sync_serial_port_fixes.sv
// Testbench of the synchronous serial port
`timescale 1ns/10ps
`default_nettype none
module test_sync_serial_port_fixes;
    logic                    sys_clk = 1'b0;
    logic                    reset_n;
    syp_pkg::syp_cfg_type    cfg;
    logic                    buf_wr;
    logic [7:0]              buf_wdata;
    logic                    buf_rd;
    logic                    ovf_clr;
    logic [7:0]              buf_q;
    syp_pkg::syp_status_type status;
    logic                    sck;
    logic                    sck_oe;
    logic                    sdo;
    logic                    sdi;
    logic                    scl;
    logic                    sda_out;
    logic                    sda_oe;
    wire logic               sda;
    int                      bad_count = 0;
    int                      tests_run = 0;
    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;
    syp_port i_syp_port (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .cfg_i(cfg), .buf_wr_i(buf_wr),
        .buf_wdata_i(buf_wdata), .buf_rd_i(buf_rd), .ovf_clr_i(ovf_clr), .buf_o(buf_q), .status_o(status),
        .sck_o(sck), .sck_oe_o(sck_oe), .sdo_o(sdo), .sdi_i(sdi), .scl_clk_i(scl), .sda_i(sda),
        .sda_o(sda_out), .sda_oe_o(sda_oe));
    syp_peer i_syp_peer (.sck_i(sck), .sdo_i(sdo), .cke_i(cfg.clock_edge_select),
        .pol_i(cfg.clock_polarity_select), .sdi_o(sdi), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Software read and overflow clear pulses
    task automatic pulse_sw(input logic rd, input logic clr);
        buf_rd = rd;
        ovf_clr = clr;
        @(negedge sys_clk);
        buf_rd = 1'b0;
        ovf_clr = 1'b0;
        @(negedge sys_clk);
    endtask
    // One SPI byte, waited out under a bound
    task automatic spi_byte(input logic [7:0] tx, input logic [7:0] rx);
        i_syp_peer.spi_load(rx);
        buf_wdata = tx;
        buf_wr = 1'b1;
        @(negedge sys_clk);
        buf_wr = 1'b0;
        @(negedge sys_clk);
        for (int n = 0; n < 1000 && status.busy !== 1'b0; n++) @(negedge sys_clk);
        check("spi done", 8'h00, {7'h00, status.busy});
        repeat (2) @(negedge sys_clk);
    endtask
    // All edge, polarity and sampling settings, enabled from off
    task automatic t_spi();
        for (int i = 0; i < 8; i++) begin
            cfg = {1'b0, 1'b1, i[0], i[1], i[2], 7'h00};
            repeat (3) @(negedge sys_clk);
            cfg.enable = 1'b1;
            repeat (4) @(negedge sys_clk);
            check("sck idle", {7'h00, i[1]}, {7'h00, sck});
            check("sck driven", 8'h01, {7'h00, sck_oe});
            spi_byte(8'h3c ^ 8'(i << 4), 8'ha5 ^ 8'(i));
            check("spi received", 8'ha5 ^ 8'(i), buf_q);
            check("peer received", 8'h3c ^ 8'(i << 4), i_syp_peer.rx_byte);
            check("spi flags", 8'h02, {6'h00, status[3:2]});
            pulse_sw(1'b1, 1'b0);
            check("flags read", 8'h00, {6'h00, status[3:2]});
        end
    endtask
    // Second byte before software read: buffer kept, overflow set
    task automatic t_spi_ovf();
        spi_byte(8'h11, 8'h77);
        spi_byte(8'h22, 8'h88);
        check("spi kept", 8'h77, buf_q);
        check("spi overflow", 8'h03, {6'h00, status[3:2]});
        pulse_sw(1'b1, 1'b1);
        check("flags cleared", 8'h00, {6'h00, status[3:2]});
    endtask
    // One I2C address frame and its verdict
    task automatic frame_chk(input logic [7:0] d, input logic e_ack, input logic [7:0] e_buf, input logic [1:0] e_fl);
        logic ack;
        i_syp_peer.i2c_start();
        i_syp_peer.i2c_byte(d, ack);
        i_syp_peer.i2c_stop();
        repeat (4) @(negedge sys_clk);
        check("ack", {7'h00, e_ack}, {7'h00, ack});
        check("sda level", 8'h00, {7'h00, sda_out});
        check("buffer", e_buf, buf_q);
        check("i2c flags", {6'h00, e_fl}, {6'h00, status[3:2]});
    endtask
    task automatic t_i2c();
        cfg = {1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 7'h5a};
        repeat (4) @(negedge sys_clk);
        frame_chk(8'h20, 1'b0, 8'h77, 2'b00);
        frame_chk(8'hb4, 1'b1, 8'hb4, 2'b10);
        frame_chk(8'hb5, 1'b0, 8'hb4, 2'b11);
        pulse_sw(1'b1, 1'b0);
        frame_chk(8'hb5, 1'b0, 8'hb4, 2'b01);
        pulse_sw(1'b0, 1'b1);
        frame_chk(8'hb5, 1'b1, 8'hb5, 2'b10);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence, inputs driven at the falling edge
    initial begin
        reset_n = 1'b0;
        cfg = '0;
        buf_wr = 1'b0;
        buf_wdata = 8'h00;
        buf_rd = 1'b0;
        ovf_clr = 1'b0;
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_spi();
        t_spi_ovf();
        t_i2c();
        test_done();
    end
    // Watchdog, tests need about 5k cycles
    initial begin
        #300000;
        bad_count++;
        test_done();
    end
endmodule
bind syp_port syp_port_checker i_syp_port_checker (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg_i),
    .buf_wr_i(buf_wr_i), .buf_wdata_i(buf_wdata_i), .buf_o(buf_o), .status_o(status_o), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sdo_o(sdo_o), .sda_oe_o(sda_oe_o));
`default_nettype wire
